// File: common/rtcf_params.svh
`ifndef RTCF_PARAMS_SVH
`define RTCF_PARAMS_SVH
// ==========================================================================
// Bus geometry.
`define RTCF_ADDR_W        17
`define RTCF_DATA_W        8
// ==========================================================================
// Register offsets.
`define RTCF_OFS_FLAGS     17'h1fff0
`define RTCF_OFS_CENT      17'h1fff1
`define RTCF_OFS_AL_SEC    17'h1fff2
`define RTCF_OFS_AL_MIN    17'h1fff3
`define RTCF_OFS_AL_HOUR   17'h1fff4
`define RTCF_OFS_INTR      17'h1fff6
// ==========================================================================
// Reset values.
`define RTCF_RST_ALARM     8'h80
`define RTCF_RST_CENT      8'h00
`define RTCF_RST_INTR      8'h08
`define RTCF_RST_PINS      30'h38000000
// ==========================================================================
// Field positions.
`define RTCF_BIT_DOG       7
`define RTCF_BIT_ALARM     6
`define RTCF_BIT_SUPPLY    5
`define RTCF_BIT_OSC       4
`define RTCF_BIT_CAL       2
`define RTCF_BIT_FREEZE    1
`define RTCF_BIT_HOLD      0
`define RTCF_BIT_DOG_IE    7
`define RTCF_BIT_ALARM_IE  6
`define RTCF_BIT_SUPPLY_IE 5
`define RTCF_BIT_HIGH      3
`define RTCF_BIT_IGNORE    7
`define RTCF_SEC_MASK      8'h7f
`define RTCF_MIN_MASK      8'h7f
`define RTCF_HOUR_MASK     8'h3f
`define RTCF_BCD_MAX       4'h9
// ==========================================================================
// Timing.
`define RTCF_CLK_HZ        200000000
`define RTCF_CAL_HZ        512
`define RTCF_OSC_CHECK_MS  5
`define RTCF_CAL_HALF_CYC  (`RTCF_CLK_HZ / (2 * `RTCF_CAL_HZ))
`define RTCF_OSC_CHECK_CYC ((`RTCF_CLK_HZ / 1000) * `RTCF_OSC_CHECK_MS)
`endif

// File: common/rtcf_pkg.sv
`default_nettype none
package rtcf_pkg;
   // ========================================================================
   // Power-up oscillator check.
   typedef enum logic [0:0] {
      RTCF_CHK_WAIT,
      RTCF_CHK_DONE
   } rtcf_chk_state_t;
   typedef logic [7:0] rtcf_byte_t;
endpackage : rtcf_pkg
`default_nettype wire

// File: verilog/rtcf_sync.sv
`default_nettype none
module rtcf_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst,
   // Data.
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;

   if (WIDTH < 1) begin : g_bad_width
      $error("rtcf_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         q       <= RST_VAL;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule // rtcf_sync
`default_nettype wire

// File: verilog/rtcf_regs.sv
// What this block does
// - A set ignore bit in the top of an alarm register drops that field from the alarm compare.
// - The centuries register counts in two BCD digits from 0 to 99.
// - A watchdog expiry sets the read-only watchdog flag.
// - A match of every non-ignored alarm field sets the read-only alarm flag.
// - A supply drop reported by the monitor sets the read-only supply flag.
// - Reading the flags register clears the watchdog, alarm and supply flags, which start at 0.
// - After power up the oscillator flag is set if the enabled oscillator has not run within 5 ms.
// - The oscillator flag survives main power cycles and is cleared only by the host writing 0 or by the backup reset.
// - The calibration bit puts a 512 Hz square wave on the interrupt pin and starts at 0.
// - The freeze bit stops time updates and opens the time, alarm and interrupt registers to writes.
// - Dropping the freeze bit after a time change loads a new base time into the counters.
// - The freeze bit is 0 after power up.
// - With the alarm interrupt enabled, a set alarm flag drives the interrupt pin.
// - With the watchdog interrupt enabled, a set watchdog flag drives the interrupt pin.
// - With the supply interrupt enabled, a set supply flag drives the interrupt pin.
// - The polarity bit selects an active-high driven pin or an open-drain active-low pin.
`default_nettype none
`include "rtcf_params.svh"
module rtcf_regs #(
   parameter int unsigned OSC_CHECK_CYC = `RTCF_OSC_CHECK_CYC,
   parameter int unsigned CAL_HALF_CYC  = `RTCF_CAL_HALF_CYC
) (
   // Clock and resets.
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      bat_rst,
   // Host bus pins.
   input  wire logic                      ce_n,
   input  wire logic                      we_n,
   input  wire logic                      oe_n,
   input  wire logic [`RTCF_ADDR_W-1:0]   addr,
   input  wire logic [`RTCF_DATA_W-1:0]   dq_i,
   output logic      [`RTCF_DATA_W-1:0]   dq_o,
   output logic                           dq_oe_n,
   // Timekeeping side.
   input  wire rtcf_pkg::rtcf_byte_t      cur_sec,
   input  wire rtcf_pkg::rtcf_byte_t      cur_min,
   input  wire rtcf_pkg::rtcf_byte_t      cur_hour,
   input  wire logic                      century_tick,
   input  wire logic                      dog_expire,
   input  wire logic                      osc_enable,
   output logic                           freeze,
   output logic                           hold,
   output logic                           load_base,
   // Monitors.
   input  wire logic                      supply_low,
   input  wire logic                      osc_running,
   // Interrupt pin.
   output logic                           int_o,
   output logic                           int_oe_n
);
   import rtcf_pkg::*;

   // =======================================================================
   // Parameter checks.
   if (OSC_CHECK_CYC < 1 || OSC_CHECK_CYC > 32'h00ffffff) begin : g_bad_chk
      $error("rtcf_regs: OSC_CHECK_CYC out of range");
   end
   if (CAL_HALF_CYC < 1 || CAL_HALF_CYC > 32'h00ffffff) begin : g_bad_cal
      $error("rtcf_regs: CAL_HALF_CYC out of range");
   end

   // =======================================================================
   // Pin synchronisers.
   logic [29:0]              pins_q;
   logic                     s_ce_n, s_we_n, s_oe_n, s_supply, s_osc;
   logic [`RTCF_ADDR_W-1:0]  s_addr;
   rtcf_byte_t               s_data;

   rtcf_sync #(.WIDTH(30), .RST_VAL(`RTCF_RST_PINS)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({ce_n, we_n, oe_n, addr, dq_i, supply_low, osc_running}),
      .q   (pins_q)
   );
   assign {s_ce_n, s_we_n, s_oe_n, s_addr, s_data, s_supply, s_osc} = pins_q;

   // =======================================================================
   // Bus cycle detection. Writes commit one cycle after the strobe ends,
   // from values captured while it was low, because data hold may be zero.
   logic                     wr_act, rd_act, wr_act_ff, rd_act_ff, wr_end, rd_start, rd_end;
   logic [`RTCF_ADDR_W-1:0]  wr_addr_ff, rd_addr_ff;
   rtcf_byte_t               wr_data_ff;

   assign wr_act   = !s_ce_n && !s_we_n;
   assign rd_act   = !s_ce_n && s_we_n && !s_oe_n;
   assign wr_end   = wr_act_ff && !wr_act;
   assign rd_start = rd_act && !rd_act_ff;
   assign rd_end   = rd_act_ff && !rd_act;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_act_ff  <= 1'b0;
         rd_act_ff  <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
         rd_addr_ff <= '0;
      end else begin
         wr_act_ff <= wr_act;
         rd_act_ff <= rd_act;
         if (wr_act) begin
            wr_addr_ff <= s_addr;
            wr_data_ff <= s_data;
         end
         if (rd_start) begin
            rd_addr_ff <= s_addr;
         end
      end
   end

   // =======================================================================
   // Control registers.
   rtcf_byte_t al_sec_ff, al_min_ff, al_hour_ff, intr_ff, century_ff, cent_hold_ff;
   logic       freeze_ff, hold_ff, cal_ff, changed_ff, load_base_ff;
   logic       wr_flags, wr_open, nxt_freeze;

   assign wr_flags   = wr_end && wr_addr_ff == `RTCF_OFS_FLAGS;
   assign wr_open    = wr_end && freeze_ff;
   assign nxt_freeze = wr_flags ? wr_data_ff[`RTCF_BIT_FREEZE] : freeze_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         al_sec_ff  <= `RTCF_RST_ALARM;
         al_min_ff  <= `RTCF_RST_ALARM;
         al_hour_ff <= `RTCF_RST_ALARM;
         intr_ff    <= `RTCF_RST_INTR;
         freeze_ff  <= 1'b0;
         hold_ff    <= 1'b0;
         cal_ff     <= 1'b0;
      end else begin
         if (wr_open && wr_addr_ff == `RTCF_OFS_AL_SEC) al_sec_ff <= wr_data_ff;
         if (wr_open && wr_addr_ff == `RTCF_OFS_AL_MIN) al_min_ff <= wr_data_ff;
         if (wr_open && wr_addr_ff == `RTCF_OFS_AL_HOUR) al_hour_ff <= wr_data_ff;
         if (wr_open && wr_addr_ff == `RTCF_OFS_INTR) intr_ff <= wr_data_ff;
         if (wr_flags) begin
            freeze_ff <= wr_data_ff[`RTCF_BIT_FREEZE];
            hold_ff   <= wr_data_ff[`RTCF_BIT_HOLD];
            cal_ff    <= wr_data_ff[`RTCF_BIT_CAL];
         end
      end
   end

   // =======================================================================
   // Centuries counter, holding copy and new-base handoff.
   function automatic rtcf_byte_t bcd_inc(input rtcf_byte_t v);
      rtcf_byte_t r;
      r = v;
      if (v[3:0] >= `RTCF_BCD_MAX) begin
         r[3:0] = 4'h0;
         r[7:4] = (v[7:4] >= `RTCF_BCD_MAX) ? 4'h0 : v[7:4] + 4'h1;
      end else begin
         r[3:0] = v[3:0] + 4'h1;
      end
      return r;
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         century_ff   <= `RTCF_RST_CENT;
         cent_hold_ff <= `RTCF_RST_CENT;
         changed_ff   <= 1'b0;
         load_base_ff <= 1'b0;
      end else begin
         if (wr_open && wr_addr_ff == `RTCF_OFS_CENT) begin
            century_ff <= wr_data_ff;
         end else if (century_tick && !freeze_ff) begin
            century_ff <= bcd_inc(century_ff);
         end
         if (!hold_ff) begin
            cent_hold_ff <= century_ff;
         end
         load_base_ff <= freeze_ff && !nxt_freeze && changed_ff;
         if (freeze_ff && !nxt_freeze) begin
            changed_ff <= 1'b0;
         end else if (wr_open && wr_addr_ff == `RTCF_OFS_CENT) begin
            changed_ff <= 1'b1;
         end
      end
   end

   // =======================================================================
   // Event flags. A set in the cycle of a read-clear wins, so no event is lost.
   logic match, match_ff, supply_ff, flags_clr;
   logic dog_timeout_flag_ff, alarm_hit_flag_ff, supply_drop_flag_ff, osc_stopped_flag_ff;

   assign match = (al_sec_ff[`RTCF_BIT_IGNORE]
                   || (cur_sec & `RTCF_SEC_MASK) == (al_sec_ff & `RTCF_SEC_MASK))
               && (al_min_ff[`RTCF_BIT_IGNORE]
                   || (cur_min & `RTCF_MIN_MASK) == (al_min_ff & `RTCF_MIN_MASK))
               && (al_hour_ff[`RTCF_BIT_IGNORE]
                   || (cur_hour & `RTCF_HOUR_MASK) == (al_hour_ff & `RTCF_HOUR_MASK));
   assign flags_clr = rd_end && rd_addr_ff == `RTCF_OFS_FLAGS;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Match history starts high, so the all-ignored alarm after power up is not a fresh match.
         match_ff            <= 1'b1;
         supply_ff           <= 1'b0;
         dog_timeout_flag_ff <= 1'b0;
         alarm_hit_flag_ff   <= 1'b0;
         supply_drop_flag_ff <= 1'b0;
      end else begin
         match_ff  <= match;
         supply_ff <= s_supply;
         if (dog_expire) dog_timeout_flag_ff <= 1'b1;
         else if (flags_clr) dog_timeout_flag_ff <= 1'b0;
         if (match && !match_ff) alarm_hit_flag_ff <= 1'b1;
         else if (flags_clr) alarm_hit_flag_ff <= 1'b0;
         if (s_supply && !supply_ff) supply_drop_flag_ff <= 1'b1;
         else if (flags_clr) supply_drop_flag_ff <= 1'b0;
      end
   end

   // =======================================================================
   // Oscillator check. The flag sits on the backup reset so a main power
   // cycle does not wipe it.
   rtcf_chk_state_t chk_state_ff;
   logic [23:0]     chk_cnt_ff;
   logic            seen_run_ff, chk_fail;

   assign chk_fail = chk_state_ff == RTCF_CHK_WAIT && chk_cnt_ff == 24'(OSC_CHECK_CYC - 1)
                     && osc_enable && !seen_run_ff && !s_osc;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chk_state_ff <= RTCF_CHK_WAIT;
         chk_cnt_ff   <= '0;
         seen_run_ff  <= 1'b0;
      end else begin
         case (chk_state_ff)
            RTCF_CHK_WAIT: begin
               seen_run_ff <= seen_run_ff || s_osc;
               chk_cnt_ff  <= chk_cnt_ff + 24'h000001;
               if (chk_cnt_ff == 24'(OSC_CHECK_CYC - 1)) chk_state_ff <= RTCF_CHK_DONE;
            end
            RTCF_CHK_DONE: chk_state_ff <= RTCF_CHK_DONE;
            default:       chk_state_ff <= RTCF_CHK_WAIT;
         endcase
      end
   end

   always_ff @(posedge clk or posedge bat_rst) begin
      if (bat_rst) begin
         osc_stopped_flag_ff <= 1'b0;
      end else if (chk_fail) begin
         osc_stopped_flag_ff <= 1'b1;
      end else if (wr_flags && !wr_data_ff[`RTCF_BIT_OSC]) begin
         osc_stopped_flag_ff <= 1'b0;
      end
   end

   // =======================================================================
   // Read data path.
   rtcf_byte_t rd_mux, dq_o_ff;
   logic       dq_oe_n_ff, rtc_hit;

   assign rtc_hit = s_addr >= `RTCF_OFS_FLAGS && s_addr <= `RTCF_OFS_AL_HOUR || s_addr == `RTCF_OFS_INTR;

   always_comb begin
      rd_mux = '0;
      case (s_addr)
         `RTCF_OFS_FLAGS:   rd_mux = {dog_timeout_flag_ff, alarm_hit_flag_ff, supply_drop_flag_ff,
                                      osc_stopped_flag_ff, 1'b0, cal_ff, freeze_ff, hold_ff};
         `RTCF_OFS_CENT:    rd_mux = cent_hold_ff;
         `RTCF_OFS_AL_SEC:  rd_mux = al_sec_ff;
         `RTCF_OFS_AL_MIN:  rd_mux = al_min_ff;
         `RTCF_OFS_AL_HOUR: rd_mux = al_hour_ff;
         `RTCF_OFS_INTR:    rd_mux = intr_ff;
         default:           rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_o_ff    <= '0;
         dq_oe_n_ff <= 1'b1;
      end else begin
         if (rd_start) dq_o_ff <= rd_mux;
         dq_oe_n_ff <= !(rd_act && (rd_start ? rtc_hit : !dq_oe_n_ff));
      end
   end

   // =======================================================================
   // Interrupt pin. Calibration mode overrides event signalling entirely.
   logic       irq, int_o_ff, int_oe_n_ff, cal_wave_ff;
   logic [23:0] cal_cnt_ff;

   assign irq = (intr_ff[`RTCF_BIT_ALARM_IE] && alarm_hit_flag_ff)
             || (intr_ff[`RTCF_BIT_DOG_IE] && dog_timeout_flag_ff)
             || (intr_ff[`RTCF_BIT_SUPPLY_IE] && supply_drop_flag_ff);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cal_cnt_ff  <= '0;
         cal_wave_ff <= 1'b0;
         int_o_ff    <= 1'b0;
         int_oe_n_ff <= 1'b1;
      end else begin
         if (!cal_ff || cal_cnt_ff == 24'(CAL_HALF_CYC - 1)) cal_cnt_ff <= '0;
         else cal_cnt_ff <= cal_cnt_ff + 24'h000001;
         if (!cal_ff) cal_wave_ff <= 1'b0;
         else if (cal_cnt_ff == 24'(CAL_HALF_CYC - 1)) cal_wave_ff <= !cal_wave_ff;
         if (cal_ff) begin
            int_o_ff    <= cal_wave_ff;
            int_oe_n_ff <= 1'b0;
         end else if (intr_ff[`RTCF_BIT_HIGH]) begin
            int_o_ff    <= irq;
            int_oe_n_ff <= 1'b0;
         end else begin
            int_o_ff    <= 1'b0;
            int_oe_n_ff <= !irq;
         end
      end
   end

   assign dq_o      = dq_o_ff;
   assign dq_oe_n   = dq_oe_n_ff;
   assign freeze    = freeze_ff;
   assign hold      = hold_ff;
   assign load_base = load_base_ff;
   assign int_o     = int_o_ff;
   assign int_oe_n  = int_oe_n_ff;

   // =======================================================================
   // Assertions.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ignore; match |-> (al_sec_ff[7] || cur_sec[6:0] == al_sec_ff[6:0]); endproperty
   a_ignore: assert property (p_ignore) else $error("alarm match with unequal unmasked seconds");
   property p_bcd; century_ff[3:0] <= `RTCF_BCD_MAX && century_ff[7:4] <= `RTCF_BCD_MAX; endproperty
   a_bcd: assert property (p_bcd) else $error("century count left BCD range");
   property p_dog; dog_expire |=> dog_timeout_flag_ff; endproperty
   a_dog: assert property (p_dog) else $error("watchdog expiry did not set flag");
   property p_alarm; $rose(match) |=> alarm_hit_flag_ff; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm match did not set flag");
   property p_clear; flags_clr && !dog_expire |=> !dog_timeout_flag_ff; endproperty
   a_clear: assert property (p_clear) else $error("flags read did not clear watchdog flag");
   property p_osc; chk_fail |=> osc_stopped_flag_ff; endproperty
   a_osc: assert property (p_osc) else $error("oscillator check did not set flag");
   property p_cal; cal_ff ##1 cal_ff |=> !int_oe_n_ff && int_o_ff == $past(cal_wave_ff); endproperty
   a_cal: assert property (p_cal) else $error("calibration wave not on interrupt pin");
   property p_frz; freeze_ff && !wr_open |=> $stable(century_ff); endproperty
   a_frz: assert property (p_frz) else $error("century changed while frozen");
   property p_base; $fell(freeze_ff) ##0 $past(changed_ff) |-> load_base_ff ##1 !load_base_ff; endproperty
   a_base: assert property (p_base) else $error("new base time not loaded once");
   property p_hold; hold_ff ##1 hold_ff |-> $stable(cent_hold_ff); endproperty
   a_hold: assert property (p_hold) else $error("holding copy moved under hold");
   property p_high; !cal_ff && intr_ff[`RTCF_BIT_HIGH] && irq |=> int_o_ff && !int_oe_n_ff; endproperty
   a_high: assert property (p_high) else $error("active-high interrupt not driven");
   property p_od; !cal_ff && !intr_ff[`RTCF_BIT_HIGH] |=> !int_o_ff && int_oe_n_ff == !$past(irq); endproperty
   a_od: assert property (p_od) else $error("open-drain interrupt wrong");

   c_alarm: cover property (alarm_hit_flag_ff && flags_clr);
   c_base:  cover property (load_base_ff);
   c_cal:   cover property (cal_ff && $rose(cal_wave_ff));
   c_osc:   cover property (chk_fail);
endmodule // rtcf_regs
`default_nettype wire

// File: bench/rtcf_host.sv
`default_nettype none
`include "rtcf_params.svh"
module rtcf_host (
   // Clock.
   input  wire logic                    clk,
   // Bus pins.
   output logic                         ce_n,
   output logic                         we_n,
   output logic                         oe_n,
   output logic [`RTCF_ADDR_W-1:0]      addr,
   output logic [`RTCF_DATA_W-1:0]      dq_i,
   input  wire logic [`RTCF_DATA_W-1:0] dq_o,
   input  wire logic                    dq_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] held;
   logic       drive;
   // A released bus shows the inverse of the last value, so stale data never reads as valid.
   assign dq_i = (dq_oe_n === 1'b0) ? dq_o : (drive ? held : ~held);
   initial begin
      ce_n = 1'b1;
      we_n = 1'b1;
      oe_n = 1'b1;
      addr = '0;
      held = 8'h00;
      drive = 1'b0;
   end
   // ========================================================================
   // Bus cycles.
   // Strobes are held six cycles because the block may miss anything under one cycle.
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      held = d;
      drive = 1'b1;
      ce_n = 1'b0;
      we_n = 1'b0;
      repeat (6) @(negedge clk);
      ce_n = 1'b1;
      we_n = 1'b1;
      drive = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic ok);
      int n;
      @(negedge clk);
      addr = a;
      ce_n = 1'b0;
      oe_n = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 8 && !ok; n++) begin
         @(negedge clk);
         if (dq_oe_n === 1'b0) begin
            ok = 1'b1;
            d = dq_o;
         end
      end
      repeat (3) @(negedge clk);
      ce_n = 1'b1;
      oe_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask
endmodule // rtcf_host
`default_nettype wire

// File: bench/rtc_alarm_and_flag_registers_tb.sv
`default_nettype none
`include "rtcf_params.svh"
module rtc_alarm_and_flag_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rtcf_pkg::*;
   localparam int unsigned OSC_CYC = 20;
   localparam int unsigned CAL_HALF = 4;
   logic clk, rst, bat_rst, ce_n, we_n, oe_n, dq_oe_n, freeze, hold, load_base, int_o, int_oe_n;
   logic century_tick, dog_expire, osc_enable, supply_low, osc_running;
   logic [16:0] addr;
   logic [7:0]  dq_i, dq_o, d;
   rtcf_byte_t  cur_sec, cur_min, cur_hour;
   logic        ok;
   int          err_count, samples_checked, base_loads, i, n;
   logic [7:0]  ie_tab [4] = '{8'h48, 8'h80, 8'h28, 8'h08};
   logic [7:0]  flag_tab [4] = '{8'h40, 8'h80, 8'h20, 8'h40};
   logic [1:0]  act_tab [4] = '{2'b10, 2'b00, 2'b10, 2'b00};
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   rtcf_regs #(.OSC_CHECK_CYC(OSC_CYC), .CAL_HALF_CYC(CAL_HALF)) u_rtcf_regs (
      .clk(clk), .rst(rst), .bat_rst(bat_rst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .cur_sec(cur_sec), .cur_min(cur_min),
      .cur_hour(cur_hour), .century_tick(century_tick), .dog_expire(dog_expire), .osc_enable(osc_enable),
      .freeze(freeze), .hold(hold), .load_base(load_base), .supply_low(supply_low),
      .osc_running(osc_running), .int_o(int_o), .int_oe_n(int_oe_n));
   rtcf_host u_rtcf_host (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_i(dq_i),
      .dq_o(dq_o), .dq_oe_n(dq_oe_n));
   always @(negedge clk) if (load_base === 1'b1) base_loads++;
   // ========================================================================
   // Checking helpers.
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [16:0] a, input logic [7:0] exp, input string what);
      u_rtcf_host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error %s expected read answer seen none", what);
         print_verdict();
      end
      check(what, exp, d);
   endtask
   task automatic pwr_up();
      @(negedge clk);
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (OSC_CYC + 10) @(negedge clk);
   endtask
   task automatic tick();
      @(negedge clk);
      century_tick = 1'b1;
      @(negedge clk);
      century_tick = 1'b0;
   endtask
   // ========================================================================
   // Main sequence.
   initial begin
      {rst, bat_rst, osc_enable, osc_running} = 4'hf;
      {century_tick, dog_expire, supply_low, err_count, samples_checked, base_loads} = '0;
      {cur_sec, cur_min, cur_hour} = '0;
      repeat (12) @(negedge clk);
      {rst, bat_rst} = 2'b00;
      repeat (OSC_CYC + 10) @(negedge clk);
      rchk(`RTCF_OFS_FLAGS, 8'h00, "flags power up");
      rchk(`RTCF_OFS_FLAGS, 8'h00, "flags idle");
      for (i = 0; i < 3; i++) rchk(`RTCF_OFS_AL_SEC + 17'(i), 8'h80, "alarm reset");
      rchk(`RTCF_OFS_CENT, 8'h00, "century reset");
      u_rtcf_host.wr(`RTCF_OFS_AL_SEC, 8'h30);
      rchk(`RTCF_OFS_AL_SEC, 8'h80, "alarm write refused");
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h02);
      check("freeze", 8'h01, {7'h0, freeze});
      u_rtcf_host.wr(`RTCF_OFS_AL_SEC, 8'h30);
      u_rtcf_host.wr(`RTCF_OFS_AL_MIN, 8'h05);
      u_rtcf_host.wr(`RTCF_OFS_CENT, 8'h09);
      rchk(`RTCF_OFS_AL_MIN, 8'h05, "alarm min");
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h00);
      check("base loads", 8'h01, 8'(base_loads));
      tick();
      rchk(`RTCF_OFS_CENT, 8'h10, "century carry");
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h02);
      u_rtcf_host.wr(`RTCF_OFS_CENT, 8'h99);
      tick();
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h00);
      tick();
      rchk(`RTCF_OFS_CENT, 8'h00, "century wrap");
      @(negedge clk);
      {cur_sec, cur_min, cur_hour} = {8'h30, 8'h05, 8'h17};
      repeat (6) @(negedge clk);
      rchk(`RTCF_OFS_FLAGS, 8'h40, "alarm hit");
      rchk(`RTCF_OFS_FLAGS, 8'h00, "flags cleared");
      cur_min = 8'h06;
      repeat (6) @(negedge clk);
      rchk(`RTCF_OFS_FLAGS, 8'h00, "minute mismatch");
      // Each entry enables one source and fires it; the last fires the alarm with nothing enabled.
      for (i = 0; i < 4; i++) begin
         u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h02);
         u_rtcf_host.wr(`RTCF_OFS_INTR, ie_tab[i]);
         u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h00);
         check("base loads", 8'h02, 8'(base_loads));
         @(negedge clk);
         if (i == 1) dog_expire = 1'b1;
         else if (i == 2) supply_low = 1'b1;
         else cur_min = 8'h05;
         @(negedge clk);
         dog_expire = 1'b0;
         repeat (6) @(negedge clk);
         check("int pin active", {6'h0, act_tab[i]}, {6'h0, int_o, int_oe_n});
         rchk(`RTCF_OFS_FLAGS, flag_tab[i], "event flag");
         check("int pin idle", {7'h0, ~ie_tab[i][3]}, {6'h0, int_o, int_oe_n});
         cur_min = 8'h06;
         supply_low = 1'b0;
      end
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h04);
      n = 0;
      for (i = 0; i < 40; i++) begin
         d[0] = int_o;
         @(negedge clk);
         if (int_o !== d[0]) n++;
      end
      check("cal edges", 8'd10, 8'(n));
      check("cal drive", 8'h00, {7'h0, int_oe_n});
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h01);
      check("hold", 8'h01, {7'h0, hold});
      tick();
      rchk(`RTCF_OFS_CENT, 8'h00, "held century");
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h00);
      check("hold", 8'h00, {7'h0, hold});
      rchk(`RTCF_OFS_CENT, 8'h01, "century after hold");
      u_rtcf_host.rd(17'h1fff5, d, ok);
      check("unmapped answer", 8'h00, {7'h0, ok});
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h02);
      osc_running = 1'b0;
      pwr_up();
      check("freeze after power up", 8'h00, {7'h0, freeze});
      u_rtcf_host.rd(`RTCF_OFS_FLAGS, d, ok);
      check("osc flag set", 8'h10, d & 8'h10);
      osc_running = 1'b1;
      pwr_up();
      u_rtcf_host.rd(`RTCF_OFS_FLAGS, d, ok);
      check("osc flag kept", 8'h10, d & 8'h10);
      u_rtcf_host.wr(`RTCF_OFS_FLAGS, 8'h00);
      u_rtcf_host.rd(`RTCF_OFS_FLAGS, d, ok);
      check("osc flag cleared", 8'h00, d & 8'h10);
      osc_enable = 1'b0;
      osc_running = 1'b0;
      pwr_up();
      u_rtcf_host.rd(`RTCF_OFS_FLAGS, d, ok);
      check("osc flag disabled", 8'h00, d & 8'h10);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("Error run length expected finish seen hang");
      print_verdict();
   end
endmodule // rtc_alarm_and_flag_registers_tb
`default_nettype wire
